// file: core/pfp_top.v
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "pfp_map.vh"

module pfp_top (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [3:0] i_fault_input,
  output wire [5:0] o_pwm_off,
  output reg [3:0] o_fault_active,
  output reg o_irq
);

  reg [7:0] fault_control_q;
  reg [7:0] fault_pin_enable_q;
  reg [7:0] fault_qualify_samples_q;
  reg [7:0] disable_map_outputs_0_1_q;
  reg [7:0] disable_map_outputs_2_3_q;
  reg [7:0] disable_map_outputs_4_5_q;
  reg [7:0] fault_status_flags_q;
  reg write_protect_q;
  reg [3:0] held_q;
  reg [3:0] held_d;
  reg [7:0] flags_d;
  reg [31:0] rdata_d;
  reg addr_ok_d;

  wire [3:0] detect;
  wire [3:0] active;
  wire [3:0] fault_irq_enable;
  wire [3:0] auto_clear;
  wire [3:0] flag_bits;
  wire [3:0] pin_en;
  wire [7:0] idx;
  wire setup_ph;
  wire wr_take;
  wire byte0_we;
  wire cfg_we;
  wire [23:0] map_all;
  wire we_fctl;
  wire we_fpin;
  wire we_fsta;
  wire we_qualify_sample_count;
  wire we_dmpa;
  wire we_dmpb;
  wire we_dmpc;
  wire we_wprot;

  // Software sees register index times four; the low two address bits are ignored.
  assign idx = i_paddr[9:2];
  assign setup_ph = i_psel & ~i_penable;
  assign wr_take = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  assign byte0_we = wr_take & i_pstrb[0];
  assign cfg_we = byte0_we & ~write_protect_q;

  assign pin_en = fault_pin_enable_q[3:0];
  assign fault_irq_enable = {fault_control_q[6], fault_control_q[4],
                             fault_control_q[2], fault_control_q[0]};
  assign auto_clear = {fault_control_q[7], fault_control_q[5],
                       fault_control_q[3], fault_control_q[1]};
  // Next-state flags, so the interrupt follows a set or a clear at the same edge.
  assign flag_bits = {flags_d[6], flags_d[4], flags_d[2], flags_d[0]};
  assign map_all = {disable_map_outputs_4_5_q, disable_map_outputs_2_3_q,
                    disable_map_outputs_0_1_q};

  function addr_mapped;
    input [7:0] a;
    begin
      case (a)
        `PFP_IDX_FCTL, `PFP_IDX_FPIN, `PFP_IDX_FSTA, `PFP_IDX_QUALIFY_SAMPLE_COUNT,
        `PFP_IDX_DMPA, `PFP_IDX_DMPB, `PFP_IDX_DMPC, `PFP_IDX_WPROT,
        `PFP_IDX_LIVE: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // One compare for every write strobe keeps the register decodes identical.
  function reg_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      reg_hit = (a == target);
    end
  endfunction

  // Protected registers see the gated strobe; status and control stay writable.
  assign we_fctl = byte0_we & reg_hit(idx, `PFP_IDX_FCTL);
  assign we_fpin = cfg_we & reg_hit(idx, `PFP_IDX_FPIN);
  assign we_fsta = byte0_we & reg_hit(idx, `PFP_IDX_FSTA);
  assign we_qualify_sample_count = cfg_we & reg_hit(idx, `PFP_IDX_QUALIFY_SAMPLE_COUNT);
  assign we_dmpa = cfg_we & reg_hit(idx, `PFP_IDX_DMPA);
  assign we_dmpb = cfg_we & reg_hit(idx, `PFP_IDX_DMPB);
  assign we_dmpc = cfg_we & reg_hit(idx, `PFP_IDX_DMPC);
  assign we_wprot = byte0_we & reg_hit(idx, `PFP_IDX_WPROT);

  // One qualifier per fault input; the pin enable alone arms it.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_qual
      pfp_qual u_qual (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_fault_input(i_fault_input[g]),
        .i_enable(pin_en[g]),
        .i_qualify_sample_count(fault_qualify_samples_q[2*g+1:2*g]),
        .o_detect(detect[g]),
        .o_active(active[g])
      );
    end
  endgenerate

  // Left unclocked on purpose: a flop here would delay every shutdown by one cycle.
  pfp_decode u_decode (
    .i_fault_input(i_fault_input),
    .i_pin_enable(pin_en),
    .i_held(held_q),
    .i_map(map_all),
    .o_pwm_off(o_pwm_off)
  );

  // Flags: a detection in the same cycle as a one-write keeps the flag set.
  integer n;
  always @*
  begin
    flags_d = fault_status_flags_q;
    if (we_fsta)
    begin
      flags_d = fault_status_flags_q & ~(i_pwdata[7:0] & `PFP_FLAG_MASK);
    end
    for (n = 0; n < 4; n = n + 1)
    begin
      if (detect[n])
      begin
        flags_d[2*n] = 1'b1;
      end
    end
  end

  // Manual mode holds the disable until software clears the flag.
  // Automatic mode drops it as soon as the qualified fault goes away.
  integer m;
  always @*
  begin
    held_d = 4'h0;
    for (m = 0; m < 4; m = m + 1)
    begin
      if (auto_clear[m])
      begin
        held_d[m] = active[m] & pin_en[m];
      end
      else
      begin
        held_d[m] = flags_d[2*m] & pin_en[m];
      end
    end
  end

  // Unused bits read as zero, so software may compare whole words.
  always @*
  begin
    addr_ok_d = addr_mapped(idx);
    rdata_d = 32'h0000_0000;
    case (idx)
      `PFP_IDX_FCTL: rdata_d[7:0] = fault_control_q;
      `PFP_IDX_FPIN: rdata_d[7:0] = fault_pin_enable_q;
      `PFP_IDX_FSTA: rdata_d[7:0] = fault_status_flags_q;
      `PFP_IDX_QUALIFY_SAMPLE_COUNT: rdata_d[7:0] = fault_qualify_samples_q;
      `PFP_IDX_DMPA: rdata_d[7:0] = disable_map_outputs_0_1_q;
      `PFP_IDX_DMPB: rdata_d[7:0] = disable_map_outputs_2_3_q;
      `PFP_IDX_DMPC: rdata_d[7:0] = disable_map_outputs_4_5_q;
      `PFP_IDX_WPROT: rdata_d[`PFP_WP_BIT] = write_protect_q;
      `PFP_IDX_LIVE: rdata_d[11:0] = {held_q, active, i_fault_input};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Every access takes exactly one wait-free access phase.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= setup_ph;
      o_pslverr <= setup_ph & ~addr_ok_d;
    end
  end

  // Read data is cleared once the bus goes idle, so no stale value is left on it.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata <= 32'h0000_0000;
    end
    else if (setup_ph && !i_pwrite)
    begin
      o_prdata <= rdata_d;
    end
    else if (!i_psel)
    begin
      o_prdata <= 32'h0000_0000;
    end
  end

  // The control register stays writable under write-protect.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_control_q <= `PFP_RST_FCTL;
    end
    else if (we_fctl)
    begin
      fault_control_q <= i_pwdata[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_pin_enable_q <= `PFP_RST_FPIN;
    end
    else if (we_fpin)
    begin
      fault_pin_enable_q <= {4'h0, i_pwdata[3:0]};
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_qualify_samples_q <= `PFP_RST_QUALIFY_SAMPLE_COUNT;
    end
    else if (we_qualify_sample_count)
    begin
      fault_qualify_samples_q <= i_pwdata[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      disable_map_outputs_0_1_q <= `PFP_RST_DMP;
    end
    else if (we_dmpa)
    begin
      disable_map_outputs_0_1_q <= i_pwdata[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      disable_map_outputs_2_3_q <= `PFP_RST_DMP;
    end
    else if (we_dmpb)
    begin
      disable_map_outputs_2_3_q <= i_pwdata[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      disable_map_outputs_4_5_q <= `PFP_RST_DMP;
    end
    else if (we_dmpc)
    begin
      disable_map_outputs_4_5_q <= i_pwdata[7:0];
    end
  end

  // Write-protect can only be set; only reset releases it.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      write_protect_q <= 1'b0;
    end
    else if (we_wprot && i_pwdata[`PFP_WP_BIT])
    begin
      write_protect_q <= 1'b1;
    end
  end

  // Flags are kept apart from the disable and interrupt state that they feed.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fault_status_flags_q <= 8'h00;
    end
    else
    begin
      fault_status_flags_q <= flags_d;
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      held_q <= 4'h0;
      o_fault_active <= 4'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      held_q <= held_d;
      o_fault_active <= held_d;
      // Driven from the next flag value so a clearing write drops it with the flag.
      o_irq <= |(flag_bits & fault_irq_enable);
    end
  end

endmodule // pfp_top

// file: core/pfp_map.vh
`ifndef PFP_MAP_VH
`define PFP_MAP_VH

// Register indices; the byte address is four times the index.
`define PFP_IDX_FCTL 8'h04
`define PFP_IDX_FPIN 8'h05
`define PFP_IDX_FSTA 8'h06
`define PFP_IDX_QUALIFY_SAMPLE_COUNT 8'h07
`define PFP_IDX_DMPA 8'h08
`define PFP_IDX_DMPB 8'h09
`define PFP_IDX_DMPC 8'h0a
`define PFP_IDX_WPROT 8'h10
`define PFP_IDX_LIVE 8'h11

// Reset values.
`define PFP_RST_FCTL 8'h00
`define PFP_RST_FPIN 8'h00
`define PFP_RST_QUALIFY_SAMPLE_COUNT 8'h00
`define PFP_RST_DMP 8'h00

// Field positions.
`define PFP_FIE_MASK 8'h55
`define PFP_FLAG_MASK 8'h55
`define PFP_WP_BIT 0

// Qualification timing in bus cycles; the code values are sample counts.
`define PFP_FIRST_SAMPLE 4'h2
`define PFP_SAMPLE_PERIOD 4'h4
`define PFP_QS_CODE0 4'h1
`define PFP_QS_CODE1 4'h5
`define PFP_QS_CODE2 4'ha
`define PFP_QS_CODE3 4'hf

`endif

// file: core/pfp_qual.v
`timescale 1ns/1ps
`include "pfp_map.vh"

module pfp_qual (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_fault_input,
  input wire i_enable,
  input wire [1:0] i_qualify_sample_count,
  output reg o_detect,
  output reg o_active
);

  localparam ST_IDLE = 2'h0;
  localparam ST_COUNT = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] st_q;
  reg [3:0] tmr_q;
  reg [3:0] smp_q;

  function [3:0] pfp_need;
    input [1:0] code;
    begin
      case (code)
        2'h0: pfp_need = `PFP_QS_CODE0;
        2'h1: pfp_need = `PFP_QS_CODE1;
        2'h2: pfp_need = `PFP_QS_CODE2;
        default: pfp_need = `PFP_QS_CODE3;
      endcase
    end
  endfunction

  // A low sample anywhere restarts the count, so only consecutive samples qualify.
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= ST_IDLE;
      tmr_q <= 4'h0;
      smp_q <= 4'h0;
      o_detect <= 1'b0;
      o_active <= 1'b0;
    end
    else
    begin
      o_detect <= 1'b0;
      if (!i_enable || !i_fault_input)
      begin
        st_q <= ST_IDLE;
        tmr_q <= 4'h0;
        smp_q <= 4'h0;
        o_active <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
          begin
            st_q <= ST_COUNT;
            tmr_q <= `PFP_FIRST_SAMPLE;
            smp_q <= 4'h0;
          end
          ST_COUNT:
          begin
            if (tmr_q == 4'h1)
            begin
              if (smp_q + 4'h1 == pfp_need(i_qualify_sample_count))
              begin
                st_q <= ST_DONE;
                o_detect <= 1'b1;
                o_active <= 1'b1;
              end
              else
              begin
                smp_q <= smp_q + 4'h1;
                tmr_q <= `PFP_SAMPLE_PERIOD;
              end
            end
            else
            begin
              tmr_q <= tmr_q - 4'h1;
            end
          end
          ST_DONE:
          begin
            o_active <= 1'b1;
          end
          default:
          begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // pfp_qual

// file: core/pfp_decode.v
`timescale 1ns/1ps

module pfp_decode (
  input wire [3:0] i_fault_input,
  input wire [3:0] i_pin_enable,
  input wire [3:0] i_held,
  input wire [23:0] i_map,
  output wire [5:0] o_pwm_off
);

  wire [3:0] fault_now;

  // Raw pins are used unclocked so outputs drop before qualification completes.
  assign fault_now = (i_fault_input & i_pin_enable) | i_held;

  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1)
    begin : g_out
      assign o_pwm_off[k] = |(i_map[4*k+3:4*k] & fault_now);
    end
  endgenerate

endmodule // pfp_decode

// file: bench/pfp_fault_src.sv
`timescale 1ns/1ps
module pfp_fault_src (
  input wire logic i_mclk,
  output logic [3:0] o_fault
);
  initial o_fault = 4'h0;
  // Pins change just after an edge, so every level is seen whole at the next edges.
  task automatic drive(input logic [3:0] v, input int n);
    o_fault <= v;
    repeat (n) @(posedge i_mclk);
  endtask
endmodule // pfp_fault_src

// file: bench/pfp_chk.sv
`timescale 1ns/1ps
module pfp_chk (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [3:0] i_fault_input,
  input wire [5:0] o_pwm_off,
  input wire [3:0] o_fault_active,
  input wire o_irq
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  ready_after_setup_a: assert property (
    i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  ready_one_cycle_a: assert property (
    o_pready |=> !o_pready) else $error("ready held too long");
  ready_needs_setup_a: assert property (
    o_pready |-> $past(i_psel && !i_penable)) else $error("ready without setup");
  err_unmapped_a: assert property (
    o_pslverr |-> o_pready && !($past(i_paddr[9:2]) inside {[8'h04:8'h0a], 8'h10, 8'h11}))
    else $error("error on mapped register");
  irq_drop_write_a: assert property (
    $fell(o_irq) |-> $past(i_psel && i_penable && i_pwrite)) else $error("irq fell alone");
  irq_rise_cause_a: assert property (
    $rose(o_irq) |-> $past(|i_fault_input, 2) || $past(i_psel) || $past(i_psel, 2))
    else $error("irq rose alone");
  pwm_off_cause_a: assert property (
    o_pwm_off != 6'h00 |-> i_fault_input != 4'h0 || o_fault_active != 4'h0)
    else $error("output off without fault");
  rdata_idle_zero_a: assert property (
    !i_psel ##1 !i_psel |-> o_prdata == 32'h0) else $error("read data not cleared");
endmodule // pfp_chk

bind pfp_top pfp_chk pfp_chk_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fault_input(i_fault_input),
  .o_pwm_off(o_pwm_off), .o_fault_active(o_fault_active), .o_irq(o_irq));

// file: bench/pwm_fault_protection_tb_top.sv
`timescale 1ns/1ps
module pwm_fault_protection_tb_top;
  logic i_mclk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, err_q;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd_q;
  logic [3:0] i_pstrb, i_fault_input, o_fault_active;
  logic [5:0] o_pwm_off;
  int miscompares = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] ix, wd, ex;} pfp_row_t;
  pfp_row_t rows [7] = '{'{8'h04, 8'hff, 8'hff}, '{8'h05, 8'hff, 8'h0f},
    '{8'h06, 8'h55, 8'h00}, '{8'h07, 8'he4, 8'he4}, '{8'h08, 8'ha5, 8'ha5},
    '{8'h09, 8'h5a, 8'h5a}, '{8'h0a, 8'h3c, 8'h3c}};
  pfp_top pfp_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_fault_input(i_fault_input), .o_pwm_off(o_pwm_off),
    .o_fault_active(o_fault_active), .o_irq(o_irq));
  pfp_fault_src pfp_fault_src_i (.i_mclk(i_mclk), .o_fault(i_fault_input));
  initial
  begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One idle edge after each transfer keeps a signal from being set twice in one step.
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= {2'b00, ix, 2'b00};
    i_pwdata <= {24'h0, d};
    @(posedge i_mclk);
    i_penable <= 1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd_q = o_prdata;
    err_q = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_mclk);
  endtask
  function automatic logic [5:0] offs(input logic [23:0] m, input logic [3:0] p);
    for (int j = 0; j < 6; j++)
      offs[j] = |(m[4*j +: 4] & p);
  endfunction
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    give_verdict;
  end
  initial
  begin
    int n;
    i_rst_n = 0;
    i_psel = 0;
    i_penable = 0;
    i_pwrite = 0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1;
    @(posedge i_mclk);
    foreach (rows[r])
    begin
      apb(0, rows[r].ix, 0);
      chk("reset value", 0, rd_q);
      apb(1, rows[r].ix, rows[r].wd);
      apb(0, rows[r].ix, 0);
      chk("read back", rows[r].ex, rd_q);
    end
    apb(0, 8'h20, 0);
    chk("unmapped", 1, err_q);
    apb(1, 8'h05, 8'h01);
    apb(1, 8'h08, 8'h01);
    apb(1, 8'h04, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      n = (c == 0) ? 1 : 5 * c;
      apb(1, 8'h07, c[7:0]);
      pfp_fault_src_i.drive(4'h1, 2 + 4 * (n - 1));
      pfp_fault_src_i.drive(4'h0, 3);
      apb(0, 8'h06, 0);
      chk("short pulse", 0, rd_q);
      pfp_fault_src_i.drive(4'h1, 3 + 4 * (n - 1));
      pfp_fault_src_i.drive(4'h0, 3);
      apb(0, 8'h06, 0);
      chk("flag", 1, rd_q);
      chk("irq", 1, o_irq);
      chk("manual hold", offs(24'h3c5a01, 4'h1), o_pwm_off);
      chk("fault held", 1, o_fault_active);
      apb(1, 8'h06, 8'h00);
      chk("zero kept", 1, o_irq);
      apb(1, 8'h06, 8'h01);
      chk("irq cleared", 0, o_irq);
      chk("hold cleared", 0, o_fault_active);
    end
    apb(1, 8'h07, 8'h00);
    apb(1, 8'h04, 8'h02);
    pfp_fault_src_i.drive(4'h1, 1);
    chk("at once", offs(24'h3c5a01, 4'h1), o_pwm_off);
    chk("not yet held", 0, o_fault_active);
    pfp_fault_src_i.drive(4'h1, 6);
    pfp_fault_src_i.drive(4'h0, 3);
    apb(0, 8'h06, 0);
    chk("idle latch", 1, rd_q);
    chk("masked", 0, o_irq);
    chk("auto release", 0, o_pwm_off);
    chk("auto held off", 0, o_fault_active);
    apb(1, 8'h06, 8'h01);
    apb(1, 8'h05, 8'h0f);
    apb(1, 8'h08, 8'h21);
    apb(1, 8'h09, 8'h84);
    apb(1, 8'h0a, 8'h31);
    for (int k = 0; k < 4; k++)
    begin
      pfp_fault_src_i.drive(4'h1 << k, 1);
      chk("map", offs(24'h318421, 4'h1 << k), o_pwm_off);
      pfp_fault_src_i.drive(4'h0, 1);
    end
    apb(1, 8'h05, 8'h00);
    pfp_fault_src_i.drive(4'hf, 1);
    chk("pin off", 0, o_pwm_off);
    pfp_fault_src_i.drive(4'h0, 1);
    apb(1, 8'h05, 8'h0f);
    apb(1, 8'h10, 8'h01);
    apb(1, 8'h05, 8'h00);
    apb(1, 8'h08, 8'h00);
    apb(0, 8'h05, 0);
    chk("locked pins", 8'h0f, rd_q);
    apb(0, 8'h08, 0);
    chk("locked map", 8'h21, rd_q);
    i_rst_n <= 0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1;
    @(posedge i_mclk);
    apb(0, 8'h05, 0);
    chk("reset again", 0, rd_q);
    give_verdict;
  end
endmodule // pwm_fault_protection_tb_top
